/* pkg/vrseq_pkg.sv */
package vrseq_pkg;
    // synchronised pin group
    typedef struct packed {
        logic power_down_n;
        logic slow_exit_n;
        logic deep_sleep_request;
        logic phase_reduce_n;
        logic [6:0] voltage_code_inputs;
        logic valley_a;
        logic valley_b;
        logic neg_a;
        logic neg_b;
        logic above_reg;
        logic ton_done_a;
        logic ton_done_b;
        logic undervoltage_trip;
        logic thermal_trip;
    } vrseq_pins_type;

    typedef enum logic [4:0] {
        VRSEQ_OFF = 5'h01,
        VRSEQ_BOOT = 5'h02,
        VRSEQ_RUN = 5'h04,
        VRSEQ_SHUT = 5'h08,
        VRSEQ_FAULT = 5'h10
    } vrseq_mode_type;

    typedef enum logic [1:0] {
        VRSEQ_SLEW_NOM = 2'h0,
        VRSEQ_SLEW_HALF = 2'h1,
        VRSEQ_SLEW_EIGHTH = 2'h2
    } vrseq_slew_type;

    localparam int CLK_PERIOD_NS = 10;
    localparam int INTEG_HOLD_NS = 20000;
    localparam logic [10:0] INTEG_CYC = 11'(INTEG_HOLD_NS / CLK_PERIOD_NS);
    localparam int SLEW_STEP_NS = 40;
    localparam logic [5:0] SLEW_NOM_CYC = 6'(SLEW_STEP_NS / CLK_PERIOD_NS);
    localparam int MIN_OFF_NS = 80;
    localparam logic [3:0] MIN_OFF_CYC = 4'((MIN_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [6:0] BOOT_CODE = 7'h30;

    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h4;
    localparam logic [3:0] ADDR_TARGET = 4'h8;
    localparam int CTRL_OVERLAP_BIT = 0;
    localparam int CTRL_NEG_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* core/vrseq_core.sv */
// Summary of operation
// R1: no new cycle while valley limit exceeded
// R2: either phase valley trip blocks both phases
// R3: forced-pwm negative limit fires on-pulse immediately
// R4: short integrator at pulse-skip code transition start
// R5: release integrator after settle, edge, 20us
// R6: below regulation at min-off: overlap both phases
// R7: overlap lasts until above at min-off end
// R8: after overlap, resume on opposite phase
// R9: startup ramps target from zero to boot
// R10: any code change starts target transition
// R11: power-down low forces lows, disabled state
// R12: power-up boots multiphase skip, eighth slew
// R13: full power: two-phase forced-pwm, nominal slew
// R14: phase reduce stops phase b, single pwm
// R15: deep sleep: single skip, blank thresholds downward
// R16: slow exit low halves slew, keeps blanking
// R17: power-down fall: flags low, multiphase ramp down
// R18: target at zero ends shutdown, low power
// R19: undervoltage or thermal latches fault until toggle
// R20: priority power-down, fault, sleep, reduce; synced
`timescale 1ns/10ps
module vrseq_core (
    input wire logic clk,
    input wire logic rst,
    input wire vrseq_pkg::vrseq_pins_type pins,
    output logic high_gate_drive_a,
    output logic high_gate_drive_b,
    output logic low_gate_drive_a,
    output logic low_gate_drive_b,
    output logic output_in_regulation,
    output logic phase_balance_ok,
    output logic cpu_clock_gate,
    output logic threshold_blank,
    output logic integrator_short,
    output logic [6:0] target_code,
    output logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid_in,
    input wire logic [3:0] s_axi_awaddr_in,
    output logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_wready,
    output logic s_axi_bvalid,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic [3:0] s_axi_araddr,
    output logic s_axi_arready,
    output logic s_axi_rvalid,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic s_axi_rready
);
    typedef struct packed {
        vrseq_pkg::vrseq_pins_type s1;
        vrseq_pkg::vrseq_pins_type s2;
        logic prev_pd_n;
        logic prev_above;
        logic [6:0] prev_code;
        vrseq_pkg::vrseq_mode_type mode;
        logic [6:0] target;
        logic [5:0] slew_cnt;
        logic on_a;
        logic on_b;
        logic [3:0] off_cnt;
        logic last_b;
        logic next_b;
        logic pre_overlap_b;
        logic overlap;
        logic integ_short;
        logic integ_wait;
        logic [10:0] integ_cnt;
        logic low_a;
        logic low_b;
        logic pgood;
        logic pbal;
        logic clk_gate;
        logic blank;
        logic [1:0] ctrl;
        logic aw_full;
        logic [3:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } vrseq_state_type;

    vrseq_state_type st;
    vrseq_state_type next_st;

    function automatic logic [5:0] slew_period(input vrseq_pkg::vrseq_slew_type s);
        case (s)
            vrseq_pkg::VRSEQ_SLEW_HALF: slew_period = 6'(vrseq_pkg::SLEW_NOM_CYC * 2);
            vrseq_pkg::VRSEQ_SLEW_EIGHTH: slew_period = 6'(vrseq_pkg::SLEW_NOM_CYC * 8);
            default: slew_period = vrseq_pkg::SLEW_NOM_CYC;
        endcase
    endfunction

    logic active;
    logic forced_pwm;
    logic multi;
    logic [6:0] goal;
    vrseq_pkg::vrseq_slew_type slew;
    logic pd_fall;
    logic pd_rise;
    logic valley_any;
    logic neg_fire_a;
    logic neg_fire_b;
    logic start_norm;
    logic min_off_end;
    logic code_change;

    always_comb begin
        next_st = st;
        // R20: two-flop pin sync
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.prev_pd_n = st.s2.power_down_n;
        next_st.prev_above = st.s2.above_reg;
        next_st.prev_code = st.s2.voltage_code_inputs;
        pd_fall = st.prev_pd_n && !st.s2.power_down_n;
        pd_rise = !st.prev_pd_n && st.s2.power_down_n;
        code_change = st.s2.voltage_code_inputs != st.prev_code;
        // R20: mode priority decode
        case (st.mode)
            vrseq_pkg::VRSEQ_OFF: begin
                // R12: rising power-down starts boot
                if (pd_rise) begin
                    next_st.mode = vrseq_pkg::VRSEQ_BOOT;
                    next_st.target = 7'h00;
                end
            end
            vrseq_pkg::VRSEQ_BOOT, vrseq_pkg::VRSEQ_RUN: begin
                // R17: falling power-down begins soft shutdown
                if (!st.s2.power_down_n) begin
                    next_st.mode = vrseq_pkg::VRSEQ_SHUT;
                // R19: fault latch
                end else if (st.s2.undervoltage_trip || st.s2.thermal_trip) begin
                    next_st.mode = vrseq_pkg::VRSEQ_FAULT;
                end else if (st.mode == vrseq_pkg::VRSEQ_BOOT &&
                             st.target == vrseq_pkg::BOOT_CODE) begin
                    next_st.mode = vrseq_pkg::VRSEQ_RUN;
                end
            end
            vrseq_pkg::VRSEQ_SHUT: begin
                // R18: zero target ends shutdown
                if (st.target == 7'h00) begin
                    next_st.mode = vrseq_pkg::VRSEQ_OFF;
                end
            end
            vrseq_pkg::VRSEQ_FAULT: begin
                // R19: toggle of power-down clears fault
                if (!st.s2.power_down_n) begin
                    next_st.mode = vrseq_pkg::VRSEQ_OFF;
                    next_st.target = 7'h00;
                end
            end
            default: next_st.mode = vrseq_pkg::VRSEQ_OFF;
        endcase
        active = st.mode == vrseq_pkg::VRSEQ_BOOT || st.mode == vrseq_pkg::VRSEQ_RUN ||
                 st.mode == vrseq_pkg::VRSEQ_SHUT;
        // R13: forced pwm in run unless deep sleep, and in shutdown
        forced_pwm = (st.mode == vrseq_pkg::VRSEQ_RUN && !st.s2.deep_sleep_request) ||
                     st.mode == vrseq_pkg::VRSEQ_SHUT;
        // R14: phase reduce and R15 deep sleep select one phase
        multi = st.mode == vrseq_pkg::VRSEQ_BOOT || st.mode == vrseq_pkg::VRSEQ_SHUT ||
                (st.mode == vrseq_pkg::VRSEQ_RUN && !st.s2.deep_sleep_request &&
                 st.s2.phase_reduce_n);
        // R9: boot goal and R10 code goal
        case (st.mode)
            vrseq_pkg::VRSEQ_BOOT: goal = vrseq_pkg::BOOT_CODE;
            vrseq_pkg::VRSEQ_RUN: goal = st.s2.voltage_code_inputs;
            default: goal = 7'h00;
        endcase
        // R16: slow exit halves slew
        if (st.mode != vrseq_pkg::VRSEQ_RUN) begin
            slew = vrseq_pkg::VRSEQ_SLEW_EIGHTH;
        end else if (st.s2.deep_sleep_request && !st.s2.slow_exit_n) begin
            slew = vrseq_pkg::VRSEQ_SLEW_HALF;
        end else begin
            slew = vrseq_pkg::VRSEQ_SLEW_NOM;
        end
        // R9: stepwise target ramp
        if (!active || st.target == goal || st.slew_cnt >= slew_period(slew) - 6'h01) begin
            next_st.slew_cnt = 6'h00;
        end else begin
            next_st.slew_cnt = st.slew_cnt + 6'h01;
        end
        if (active && st.target != goal && st.slew_cnt >= slew_period(slew) - 6'h01) begin
            next_st.target = (st.target < goal) ? st.target + 7'h01 : st.target - 7'h01;
        end
        // switching: on-time end and min-off
        if (st.on_a && st.s2.ton_done_a) begin
            next_st.on_a = 1'b0;
        end
        if (st.on_b && st.s2.ton_done_b) begin
            next_st.on_b = 1'b0;
        end
        if ((st.on_a && !next_st.on_a) || (st.on_b && !next_st.on_b)) begin
            next_st.off_cnt = vrseq_pkg::MIN_OFF_CYC;
        end else if (st.off_cnt != 4'h0) begin
            next_st.off_cnt = st.off_cnt - 4'h1;
        end
        min_off_end = st.off_cnt == 4'h1;
        // R6: below regulation at min-off end enters overlap
        if (min_off_end && !st.s2.above_reg && multi && st.ctrl[vrseq_pkg::CTRL_OVERLAP_BIT]) begin
            if (!st.overlap) begin
                next_st.pre_overlap_b = st.last_b;
            end
            next_st.overlap = 1'b1;
        // R7: overlap ends when above at min-off end, or when not active
        end else if (min_off_end && st.s2.above_reg && st.overlap) begin
            next_st.overlap = 1'b0;
            // R8: resume on opposite phase
            next_st.next_b = !st.pre_overlap_b;
        end
        valley_any = st.s2.valley_a || st.s2.valley_b;
        // R1: valley limit blocks start; R2: either phase blocks both
        start_norm = active && !st.on_a && !st.on_b && st.off_cnt == 4'h0 &&
                     !st.s2.above_reg && !valley_any;
        if (start_norm) begin
            if (st.overlap && multi) begin
                next_st.on_a = 1'b1;
                next_st.on_b = 1'b1;
            end else if (st.next_b && multi) begin
                next_st.on_b = 1'b1;
                next_st.last_b = 1'b1;
                next_st.next_b = 1'b0;
            end else begin
                next_st.on_a = 1'b1;
                next_st.last_b = 1'b0;
                next_st.next_b = multi;
            end
        end
        // R3: negative limit immediate pulse in forced pwm
        neg_fire_a = forced_pwm && st.ctrl[vrseq_pkg::CTRL_NEG_BIT] && st.s2.neg_a && !st.on_a;
        neg_fire_b = forced_pwm && st.ctrl[vrseq_pkg::CTRL_NEG_BIT] && st.s2.neg_b &&
                     !st.on_b && multi;
        if (neg_fire_a) begin
            next_st.on_a = 1'b1;
        end
        if (neg_fire_b) begin
            next_st.on_b = 1'b1;
        end
        // R11: disabled states hold drives off
        if (!active) begin
            next_st.on_a = 1'b0;
            next_st.on_b = 1'b0;
            next_st.overlap = 1'b0;
            next_st.off_cnt = 4'h0;
        end
        // R14: phase b stopped when not multiphase
        if (!multi) begin
            next_st.on_b = 1'b0;
        end
        next_st.low_a = active && !next_st.on_a;
        next_st.low_b = active && multi && !next_st.on_b;
        // R4: short integrator at pulse-skip transition start
        if (st.mode == vrseq_pkg::VRSEQ_RUN && st.s2.deep_sleep_request && code_change) begin
            next_st.integ_short = 1'b1;
            next_st.integ_wait = 1'b0;
            next_st.integ_cnt = 11'h000;
        // R5: settle, comparator edge, then hold time
        end else if (st.integ_short && !st.integ_wait && st.target == goal &&
                     st.s2.above_reg && !st.prev_above) begin
            next_st.integ_wait = 1'b1;
            next_st.integ_cnt = 11'h000;
        end else if (st.integ_wait) begin
            if (st.integ_cnt == vrseq_pkg::INTEG_CYC - 11'h001) begin
                next_st.integ_short = 1'b0;
                next_st.integ_wait = 1'b0;
            end else begin
                next_st.integ_cnt = st.integ_cnt + 11'h001;
            end
        end
        // R17: flags drop at once on shutdown
        next_st.pgood = next_st.mode == vrseq_pkg::VRSEQ_RUN && !pd_fall && st.target == goal;
        next_st.pbal = next_st.mode == vrseq_pkg::VRSEQ_RUN && !pd_fall;
        next_st.clk_gate = !next_st.pgood;
        // R15: blank upper thresholds downward; R16 always when slow
        next_st.blank = st.mode == vrseq_pkg::VRSEQ_RUN && st.s2.deep_sleep_request &&
                        (goal < st.target || !st.s2.slow_exit_n);
        // register bus slave
        if (s_axi_awvalid_in && s_axi_awready) begin
            next_st.aw_full = 1'b1;
            next_st.aw_addr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_full = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.aw_full && st.w_full && !st.bvalid) begin
            next_st.aw_full = 1'b0;
            next_st.w_full = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = vrseq_pkg::RESP_OKAY;
            if (st.aw_addr == vrseq_pkg::ADDR_CTRL) begin
                if (st.w_strb[0]) begin
                    next_st.ctrl = st.w_data[1:0];
                end
            end else if (st.aw_addr != vrseq_pkg::ADDR_STATUS &&
                         st.aw_addr != vrseq_pkg::ADDR_TARGET) begin
                next_st.bresp = vrseq_pkg::RESP_SLVERR;
            end
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = vrseq_pkg::RESP_OKAY;
            case (s_axi_araddr)
                vrseq_pkg::ADDR_CTRL: next_st.rdata = {30'h0, st.ctrl};
                vrseq_pkg::ADDR_STATUS: next_st.rdata = {21'h0, st.mode, st.integ_short,
                                                         st.overlap, st.last_b, st.on_b,
                                                         st.on_a, st.pgood};
                vrseq_pkg::ADDR_TARGET: next_st.rdata = {17'h0, goal, 1'b0, st.target};
                default: begin
                    next_st.rdata = 32'h0;
                    next_st.rresp = vrseq_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
            st.mode <= vrseq_pkg::VRSEQ_OFF;
            st.ctrl <= vrseq_pkg::CTRL_RESET;
            st.clk_gate <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready = !st.aw_full && !st.bvalid;
    assign s_axi_wready = !st.w_full && !st.bvalid;
    assign s_axi_arready = !st.rvalid;
    assign s_axi_awaddr = st.aw_addr;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign high_gate_drive_a = st.on_a;
    assign high_gate_drive_b = st.on_b;
    assign low_gate_drive_a = st.low_a;
    assign low_gate_drive_b = st.low_b;
    assign output_in_regulation = st.pgood;
    assign phase_balance_ok = st.pbal;
    assign cpu_clock_gate = st.clk_gate;
    assign threshold_blank = st.blank;
    assign integrator_short = st.integ_short;
    assign target_code = st.target;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence pd_fall_s;
        st.prev_pd_n && !st.s2.power_down_n;
    endsequence
    sequence flags_low_s;
        !st.pgood && !st.pbal && st.clk_gate;
    endsequence

    // R11: off forces low drives
    off_lows_a: assert property (st.mode == vrseq_pkg::VRSEQ_OFF |=> !low_gate_drive_a &&
        !low_gate_drive_b && !high_gate_drive_a) else $error("drives on while off"); // R11
    // R2: valley blocks starts
    valley_block_a: assert property ($rose(st.on_a) && !$past(neg_fire_a) |->
        !$past(valley_any)) else $error("start during valley limit"); // R2
    // R3: negative limit pulse
    neg_pulse_a: assert property (neg_fire_a |=> high_gate_drive_a && !low_gate_drive_a)
        else $error("negative limit pulse missing"); // R3
    // R4: integrator short
    integ_short_a: assert property (st.mode == vrseq_pkg::VRSEQ_RUN &&
        st.s2.deep_sleep_request && code_change |=> integrator_short)
        else $error("integrator not shorted"); // R4
    // R5: integrator hold time
    integ_hold_a: assert property ($fell(st.integ_short) |-> $past(st.integ_wait) &&
        $past(st.integ_cnt) == vrseq_pkg::INTEG_CYC - 11'h001)
        else $error("integrator released early"); // R5
    // R14: single phase
    phase_b_off_a: assert property (!multi |=> !high_gate_drive_b && !low_gate_drive_b)
        else $error("phase b active in single phase"); // R14
    // R17: shutdown flags
    shut_flags_a: assert property (pd_fall_s ##0 st.mode == vrseq_pkg::VRSEQ_RUN |=>
        flags_low_s ##0 st.mode == vrseq_pkg::VRSEQ_SHUT)
        else $error("shutdown flags wrong"); // R17
    // R19: fault holds
    fault_hold_a: assert property (st.mode == vrseq_pkg::VRSEQ_FAULT && st.s2.power_down_n
        |=> st.mode == vrseq_pkg::VRSEQ_FAULT) else $error("fault latch lost"); // R19
    // R9: ramp by one step
    ramp_step_a: assert property (active && $changed(st.target) |->
        st.target - $past(st.target) == 7'h01 || $past(st.target) - st.target == 7'h01)
        else $error("target stepped"); // R9
    // R18: zero ends shutdown
    shut_end_a: assert property (st.mode == vrseq_pkg::VRSEQ_SHUT && st.target == 7'h00
        |=> st.mode == vrseq_pkg::VRSEQ_OFF) else $error("shutdown did not end"); // R18
endmodule // vrseq_core

/* verification/vrseq_proc_model.sv */
`timescale 1ns/10ps
module vrseq_proc_model (
    input wire logic clk,
    input wire vrseq_pkg::vrseq_pins_type ctl,
    input wire logic high_gate_drive_a,
    input wire logic high_gate_drive_b,
    output vrseq_pkg::vrseq_pins_type pins
);
    logic [2:0] on_a;
    logic [2:0] on_b;
    // one-shots expire four cycles into a high-side pulse
    always_ff @(posedge clk) begin
        on_a <= high_gate_drive_a ? (on_a[2] ? on_a : on_a + 3'h1) : 3'h0;
        on_b <= high_gate_drive_b ? (on_b[2] ? on_b : on_b + 3'h1) : 3'h0;
    end
    always_comb begin
        pins = ctl;
        pins.ton_done_a = on_a[2];
        pins.ton_done_b = on_b[2];
    end
endmodule // vrseq_proc_model

/* verification/tb_vrseq_core.sv */
`timescale 1ns/10ps
module tb_vrseq_core;
    logic clk, rst, pa, pb;
    vrseq_pkg::vrseq_pins_type ctl, pins;
    logic hi_a, hi_b, lo_a, lo_b, pgood, pbal, cgate, blank, ishort;
    logic [6:0] target, code;
    logic awv, awr, wv, wr, bv, bready, arv, arr, rv, rready;
    logic [3:0] awa, ara, ws;
    logic [31:0] wd, rdata, rd;
    logic [1:0] bresp, rresp, rsp;
    int errors, checked, cyc, ra, rb, n;

    vrseq_proc_model vrseq_proc_model_i (.clk(clk), .ctl(ctl), .high_gate_drive_a(hi_a),
        .high_gate_drive_b(hi_b), .pins(pins));
    vrseq_core vrseq_core_i (.clk(clk), .rst(rst), .pins(pins), .high_gate_drive_a(hi_a),
        .high_gate_drive_b(hi_b), .low_gate_drive_a(lo_a), .low_gate_drive_b(lo_b),
        .output_in_regulation(pgood), .phase_balance_ok(pbal), .cpu_clock_gate(cgate),
        .threshold_blank(blank), .integrator_short(ishort), .target_code(target),
        .s_axi_awaddr(), .s_axi_awvalid_in(awv), .s_axi_awaddr_in(awa), .s_axi_awready(awr),
        .s_axi_wvalid(wv), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wready(wr),
        .s_axi_bvalid(bv), .s_axi_bresp(bresp), .s_axi_bready(bready), .s_axi_arvalid(arv),
        .s_axi_araddr(ara), .s_axi_arready(arr), .s_axi_rvalid(rv), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rready(rready));

    task automatic test_done();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] exp_mode(input vrseq_pkg::vrseq_mode_type m);
        return {21'h0, m, 6'h0};
    endfunction

    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic wait_tgt(input logic [6:0] g);
        for (int i = 0; i < 4000 && target !== g; i++) @(posedge clk);
    endtask

    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        ws <= 4'hf;
        bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge clk);
            if (awv && awr) begin
                aw_done = 1'b1;
                awv <= 1'b0;
            end
            if (wv && wr) begin
                w_done = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (bv !== 1'b1);
        rsp = bresp;
    endtask

    task automatic bus_rd(input logic [3:0] a);
        arv <= 1'b1;
        ara <= a;
        rready <= 1'b1;
        do @(posedge clk); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rv !== 1'b1) @(posedge clk);
        rd = rdata;
        rsp = rresp;
    endtask

    task automatic mode_is(input vrseq_pkg::vrseq_mode_type m);
        bus_rd(vrseq_pkg::ADDR_STATUS);
        chk(rd & 32'h7c0, exp_mode(m));
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (hi_a && !pa) ra++;
        if (hi_b && !pb) rb++;
        pa = hi_a;
        pb = hi_b;
        if (cyc == 30000) begin
            errors++;
            test_done();
        end
    end

    initial begin
        void'($urandom(32'h3a32));
        ctl = '0;
        ctl.slow_exit_n = 1'b1;
        ctl.phase_reduce_n = 1'b1;
        ctl.voltage_code_inputs = 7'h30;
        {awv, awa, wv, wd, ws, bready, arv, ara, rready} = '0;
        rst = 1'b1;
        tick(16);
        rst <= 1'b0;
        tick(2);
        chk(32'({lo_a, lo_b, hi_a, hi_b, cgate}), 32'h1);
        bus_rd(vrseq_pkg::ADDR_CTRL);
        chk(rd, 32'h3);
        mode_is(vrseq_pkg::VRSEQ_OFF);
        bus_rd(4'hc);
        chk(32'(rsp), 32'(vrseq_pkg::RESP_SLVERR));
        bus_wr(vrseq_pkg::ADDR_STATUS, 32'hffffffff);
        chk(32'(rsp), 32'(vrseq_pkg::RESP_OKAY));
        bus_wr(4'hc, 32'h0);
        chk(32'(rsp), 32'(vrseq_pkg::RESP_SLVERR));
        bus_wr(vrseq_pkg::ADDR_CTRL, 32'h1);
        bus_rd(vrseq_pkg::ADDR_CTRL);
        chk(rd, 32'h1);
        bus_wr(vrseq_pkg::ADDR_CTRL, 32'h3);
        $display("test reset done");
        ctl.power_down_n <= 1'b1;
        tick(6);
        mode_is(vrseq_pkg::VRSEQ_BOOT);
        tick(100);
        chk(32'(target >= 7'h2 && target <= 7'h4), 32'h1);
        wait_tgt(7'h30);
        tick(10);
        n = rb;
        tick(200);
        chk(32'({pgood, pbal, rb != n}), 32'h7);
        mode_is(vrseq_pkg::VRSEQ_RUN);
        chk(32'(rd[4]), 32'h1);
        $display("test boot done");
        for (int i = 0; i < 4; i++) begin
            code = (i == 0) ? 7'h7f : 7'($urandom_range(8, 120));
            ctl.voltage_code_inputs <= code;
            tick(5);
            wait_tgt(code);
            chk(32'(target), 32'(code));
        end
        $display("test code done");
        ctl.valley_b <= 1'b1;
        tick(4);
        n = ra + rb;
        tick(100);
        chk(ra + rb, n);
        ctl.valley_b <= 1'b0;
        tick(60);
        chk(32'(ra + rb != n), 32'h1);
        ctl.above_reg <= 1'b1;
        tick(20);
        ctl.neg_a <= 1'b1;
        for (int i = 0; i < 8 && hi_a !== 1'b1; i++) @(posedge clk);
        chk(32'({hi_a, lo_a}), 32'h2);
        tick(30);
        bus_rd(vrseq_pkg::ADDR_STATUS);
        chk(32'(rd[4]), 32'h0);
        ctl.neg_a <= 1'b0;
        ctl.above_reg <= 1'b0;
        ctl.phase_reduce_n <= 1'b0;
        tick(6);
        n = rb;
        tick(150);
        chk(32'({rb != n, hi_b, lo_b}), 32'h0);
        ctl.phase_reduce_n <= 1'b1;
        $display("test limits done");
        ctl.deep_sleep_request <= 1'b1;
        ctl.voltage_code_inputs <= code - 7'h8;
        tick(6);
        n = rb;
        chk(32'({blank, ishort}), 32'h3);
        wait_tgt(code - 7'h8);
        chk(32'({rb != n, hi_b, lo_b}), 32'h0);
        ctl.above_reg <= 1'b1;
        tick(1900);
        chk(32'(ishort), 32'h1);
        tick(200);
        chk(32'(ishort), 32'h0);
        ctl.slow_exit_n <= 1'b0;
        tick(6);
        chk(32'(blank), 32'h1);
        ctl.voltage_code_inputs <= code;
        tick(40);
        chk(32'(target), 32'(code - 7'h4));
        ctl.slow_exit_n <= 1'b1;
        ctl.deep_sleep_request <= 1'b0;
        ctl.above_reg <= 1'b0;
        $display("test sleep done");
        ctl.power_down_n <= 1'b0;
        tick(5);
        chk(32'({pgood, pbal, cgate}), 32'h1);
        mode_is(vrseq_pkg::VRSEQ_SHUT);
        wait_tgt(7'h0);
        tick(6);
        mode_is(vrseq_pkg::VRSEQ_OFF);
        chk(32'({lo_a, lo_b}), 32'h0);
        ctl.power_down_n <= 1'b1;
        tick(5);
        wait_tgt(7'h30);
        ctl.undervoltage_trip <= 1'b1;
        tick(2);
        ctl.undervoltage_trip <= 1'b0;
        tick(50);
        mode_is(vrseq_pkg::VRSEQ_FAULT);
        chk(32'({hi_a, hi_b, lo_a, lo_b}), 32'h0);
        ctl.power_down_n <= 1'b0;
        tick(6);
        mode_is(vrseq_pkg::VRSEQ_OFF);
        $display("test fault done");
        test_done();
    end
endmodule // tb_vrseq_core
